// ==== src/dtd_pkg.sv ====
// Constants, field layouts and types shared by the dual 8-bit timer block.
// Assumes a single 200 MHz system clock; the high-frequency clock is that clock.
package dtd_pkg;
   // Channel count and counter width
   localparam int CH_N   = 2;
   localparam int DATA_W = 8;
   // Register byte offsets on the AXI4-Lite bus
   localparam logic [7:0] OFS_CMP0  = 8'h00;
   localparam logic [7:0] OFS_CTRL0 = 8'h04;
   localparam logic [7:0] OFS_CMP1  = 8'h08;
   localparam logic [7:0] OFS_CTRL1 = 8'h0C;
   localparam logic [7:0] OFS_CFG   = 8'h10;
   localparam logic [7:0] OFS_STAT  = 8'h14;
   // Field positions
   localparam int CFG_TAP_BIT  = 0;
   localparam int CFG_SLOW_BIT = 1;
   localparam int STAT_FF_BIT  = 16;
   // Reset values
   localparam logic [7:0] CMP_RST  = 8'h00;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [1:0] CFG_RST  = 2'h0;
   // Prescaler tap exponents (divide by two to the power)
   localparam int TAP_FC11 = 11;
   localparam int TAP_FC7  = 7;
   localparam int TAP_FC5  = 5;
   localparam int TAP_FC3  = 3;
   localparam int TAP_FS3  = 3;
   // Bus responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Operating modes handled here
   typedef enum logic [2:0] {
      MODE_TIMER   = 3'h0,
      MODE_DIVIDER = 3'h1
   } dtd_mode_t;
   // Source clock selections
   typedef enum logic [2:0] {
      SRC_FC11 = 3'h0,
      SRC_FC7  = 3'h1,
      SRC_FC5  = 3'h2,
      SRC_FC3  = 3'h3,
      SRC_PIN  = 3'h7
   } dtd_src_t;
   // Channel control register layout
   typedef struct packed {
      logic      ffInit;
      dtd_src_t  srcSel;
      logic      run;
      dtd_mode_t mode;
   } dtd_ctrl_t;
endpackage : dtd_pkg

// ==== src/dtd_timer.sv ====
// Dual 8-bit timer, event counter and programmable divider with AXI4-Lite registers.
// Assumes one clock (clk, 200 MHz) and a synchronous active-high reset.
// Behaviour
// - Two identical 8-bit counter channels; chaining into 16 bits is not built.
// - Timer mode counts internal ticks; on compare match raise match, clear, continue.
// - Timer compare writes act immediately; software avoids changing them while running.
// - Event mode counts falling pin edges; on match raise match, clear, continue.
// - Event mode compare writes act immediately; software avoids changes while counting.
// - Divider mode counts internal ticks; match toggles flip-flop, clears, raises match.
// - Divider output is a square wave, each phase one compare period.
// - Divider pin always drives the inverse of the output flip-flop.
// - Control bit preloads the output flip-flop on control writes while stopped; reset clears it to 0.
// - Divider mode compare writes act immediately; software avoids changes while running.
// - Stopped divider holds pin level; later initial-value write changes the pin.
// - Control bit 3 is run, bit 7 initial value; clearing 7 stopped drives pin high.
// - 8'h10 selects fc/2^7 timer, 8'h18 starts it, 8'h11 selects divider mode.
// - Mode field 000 is timer or event counter, 001 divider; others unused here.
//
// Implementation choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module dtd_timer (
   // Clock and reset
   input  wire logic                          clk,
   input  wire logic                          reset,
   // AXI4-Lite write address and data
   input  wire logic                          s_axi_awvalid,
   output logic                               s_axi_awready,
   input  wire logic [7:0]                    s_axi_awaddr,
   input  wire logic                          s_axi_wvalid,
   output logic                               s_axi_wready,
   input  wire logic [31:0]                   s_axi_wdata,
   input  wire logic [3:0]                    s_axi_wstrb,
   // AXI4-Lite write response
   output logic                               s_axi_bvalid,
   input  wire logic                          s_axi_bready,
   output logic [1:0]                         s_axi_bresp,
   // AXI4-Lite read
   input  wire logic                          s_axi_arvalid,
   output logic                               s_axi_arready,
   input  wire logic [7:0]                    s_axi_araddr,
   output logic                               s_axi_rvalid,
   input  wire logic                          s_axi_rready,
   output logic [31:0]                        s_axi_rdata,
   output logic [1:0]                         s_axi_rresp,
   // External pins
   input  wire logic [dtd_pkg::CH_N-1:0]      eventCountPin,
   input  wire logic                          lowFreqClockPin,
   output logic [dtd_pkg::CH_N-1:0]           dividerOutputPin,
   output logic [dtd_pkg::CH_N-1:0]           channelMatchIrq
);
   import dtd_pkg::*;

   // Every assertion below runs on clk and is off during reset
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   // Offset of a channel's compare or control register
   function automatic logic [7:0] chanOfs(input int ch, input logic isCtrl);
      logic [7:0] base;
      base = (ch == 0) ? OFS_CMP0 : OFS_CMP1;
      return isCtrl ? base + (OFS_CTRL0 - OFS_CMP0) : base;
   endfunction : chanOfs

   // Tick of the selected source clock
   function automatic logic srcTick(input dtd_src_t sel, input logic [10:0] presc,
                                    input logic fsTick, input logic tapSel,
                                    input logic slow, input logic pinFall);
      logic t;
      t = 1'b0;
      case (sel)
         SRC_FC11: t = (tapSel || slow) ? fsTick : &presc[TAP_FC11-1:0];
         SRC_FC7:  t = !slow && &presc[TAP_FC7-1:0];
         SRC_FC5:  t = !slow && &presc[TAP_FC5-1:0];
         SRC_FC3:  t = !slow && &presc[TAP_FC3-1:0];
         SRC_PIN:  t = pinFall;
         default:  t = 1'b0;
      endcase
      return t;
   endfunction : srcTick

   // Bus state
   logic              awHave_q, awHave_d, wHave_q, wHave_d;
   logic [7:0]        awAddr_q, awAddr_d;
   logic [7:0]        wData_q, wData_d;
   logic              wStrb_q, wStrb_d;
   logic              bValid_q, bValid_d, rValid_q, rValid_d;
   logic [1:0]        bResp_q, bResp_d, rResp_q, rResp_d;
   logic [31:0]       rData_q, rData_d;
   logic              wrDo;
   // Register state
   logic [7:0]        cmp_q [CH_N];
   logic [7:0]        cmp_d [CH_N];
   dtd_ctrl_t         ctrl_q [CH_N];
   dtd_ctrl_t         ctrl_d [CH_N];
   logic [1:0]        cfg_q, cfg_d;
   // Channel state
   logic [7:0]        cnt_q [CH_N];
   logic [CH_N-1:0]   ff_q, match;
   logic [CH_N-1:0]   wrCtrl;
   // Prescaler and pin synchronisers
   logic [10:0]       presc_q, presc_d;
   logic [2:0]        fsCnt_q, fsCnt_d;
   logic [CH_N:0]     s1_q, s2_q, s3_q, stable_q, stable_d, fall, rise;
   logic              fsTick;

   // Handshakes straight from the pending flags
   assign s_axi_awready = !awHave_q;
   assign s_axi_wready  = !wHave_q;
   assign s_axi_arready = !rValid_q;
   assign s_axi_bvalid  = bValid_q;
   assign s_axi_bresp   = bResp_q;
   assign s_axi_rvalid  = rValid_q;
   assign s_axi_rdata   = rData_q;
   assign s_axi_rresp   = rResp_q;
   assign wrDo          = awHave_q && wHave_q && !bValid_q;

   // Bus slave next state: address and data taken in either order, one write in flight
   always_comb begin
      awHave_d = awHave_q;
      awAddr_d = awAddr_q;
      wHave_d  = wHave_q;
      wData_d  = wData_q;
      wStrb_d  = wStrb_q;
      bValid_d = bValid_q;
      bResp_d  = bResp_q;
      rValid_d = rValid_q;
      rData_d  = rData_q;
      rResp_d  = rResp_q;
      if (s_axi_awvalid && !awHave_q) begin
         awHave_d = 1'b1;
         awAddr_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && !wHave_q) begin
         wHave_d = 1'b1;
         wData_d = s_axi_wdata[7:0];
         wStrb_d = s_axi_wstrb[0];
      end
      if (wrDo) begin
         awHave_d = 1'b0;
         wHave_d  = 1'b0;
         bValid_d = 1'b1;
         bResp_d  = (awAddr_q[1:0] == 2'h0 && awAddr_q <= OFS_CFG) ? RESP_OKAY : RESP_SLVERR;
      end
      if (bValid_q && s_axi_bready) begin
         bValid_d = 1'b0;
      end
      if (rValid_q && s_axi_rready) begin
         rValid_d = 1'b0;
      end
      if (s_axi_arvalid && !rValid_q) begin
         rValid_d = 1'b1;
         rResp_d  = RESP_OKAY;
         case (s_axi_araddr)
            OFS_CMP0:  rData_d = {24'h000000, cmp_q[0]};
            OFS_CTRL0: rData_d = {24'h000000, ctrl_q[0]};
            OFS_CMP1:  rData_d = {24'h000000, cmp_q[1]};
            OFS_CTRL1: rData_d = {24'h000000, ctrl_q[1]};
            OFS_CFG:   rData_d = {30'h00000000, cfg_q};
            OFS_STAT:  rData_d = {14'h0000, ff_q, cnt_q[1], cnt_q[0]};
            default: begin
               rData_d = 32'h00000000;
               rResp_d = RESP_SLVERR;
            end
         endcase
      end
   end

   // Bus slave registers
   always_ff @(posedge clk) begin
      if (reset) begin
         awHave_q <= 1'b0;
         awAddr_q <= 8'h00;
         wHave_q  <= 1'b0;
         wData_q  <= 8'h00;
         wStrb_q  <= 1'b0;
         bValid_q <= 1'b0;
         bResp_q  <= RESP_OKAY;
         rValid_q <= 1'b0;
         rData_q  <= 32'h00000000;
         rResp_q  <= RESP_OKAY;
      end else begin
         awHave_q <= awHave_d;
         awAddr_q <= awAddr_d;
         wHave_q  <= wHave_d;
         wData_q  <= wData_d;
         wStrb_q  <= wStrb_d;
         bValid_q <= bValid_d;
         bResp_q  <= bResp_d;
         rValid_q <= rValid_d;
         rData_q  <= rData_d;
         rResp_q  <= rResp_d;
      end
   end

   // Register file next values; compare writes land at once, unbuffered
   always_comb begin
      cfg_d = cfg_q;
      if (wrDo && wStrb_q && awAddr_q == OFS_CFG) begin
         cfg_d = wData_q[1:0];
      end
      for (int i = 0; i < CH_N; i++) begin
         cmp_d[i]  = cmp_q[i];
         ctrl_d[i] = ctrl_q[i];
         wrCtrl[i] = wrDo && wStrb_q && awAddr_q == chanOfs(i, 1'b1);
         if (wrDo && wStrb_q && awAddr_q == chanOfs(i, 1'b0)) begin
            cmp_d[i] = wData_q;
         end
         if (wrCtrl[i]) begin
            ctrl_d[i] = dtd_ctrl_t'(wData_q);
         end
      end
   end

   // Register file
   always_ff @(posedge clk) begin
      if (reset) begin
         cfg_q <= CFG_RST;
         for (int i = 0; i < CH_N; i++) begin
            cmp_q[i]  <= CMP_RST;
            ctrl_q[i] <= dtd_ctrl_t'(CTRL_RST);
         end
      end else begin
         cfg_q <= cfg_d;
         for (int i = 0; i < CH_N; i++) begin
            cmp_q[i]  <= cmp_d[i];
            ctrl_q[i] <= ctrl_d[i];
         end
      end
   end

   // Three-stage pin synchronisers; a level counts once stages two and three agree
   always_comb begin
      for (int k = 0; k <= CH_N; k++) begin
         stable_d[k] = (s2_q[k] == s3_q[k]) ? s3_q[k] : stable_q[k];
         fall[k]     = stable_q[k] && !s2_q[k] && !s3_q[k];
         rise[k]     = !stable_q[k] && s2_q[k] && s3_q[k];
      end
      fsTick  = rise[CH_N] && (fsCnt_q == 3'((1 << TAP_FS3) - 1));
      fsCnt_d = rise[CH_N] ? fsCnt_q + 3'h1 : fsCnt_q;
      presc_d = presc_q + 11'h001;
   end

   // Synchroniser and prescaler registers
   always_ff @(posedge clk) begin
      if (reset) begin
         // Idle levels: count pins high, slow clock low, so no false edge after reset
         s1_q     <= {1'b0, {CH_N{1'b1}}};
         s2_q     <= {1'b0, {CH_N{1'b1}}};
         s3_q     <= {1'b0, {CH_N{1'b1}}};
         stable_q <= {1'b0, {CH_N{1'b1}}};
         fsCnt_q  <= 3'h0;
         presc_q  <= 11'h000;
      end else begin
         s1_q     <= {lowFreqClockPin, eventCountPin};
         s2_q     <= s1_q;
         s3_q     <= s2_q;
         stable_q <= stable_d;
         fsCnt_q  <= fsCnt_d;
         presc_q  <= presc_d;
      end
   end

   // Two identical channels
   for (genvar c = 0; c < CH_N; c++) begin : g_ch
      logic [7:0] cnt_d;
      logic       ff_d, tick, active;
      logic [7:0] cntNext;

      // Counter, match and output flip-flop next values
      always_comb begin
         active  = ctrl_q[c].run &&
                   (ctrl_q[c].mode == MODE_TIMER || ctrl_q[c].mode == MODE_DIVIDER);
         tick    = active && srcTick(ctrl_q[c].srcSel, presc_q, fsTick,
                                     cfg_q[CFG_TAP_BIT], cfg_q[CFG_SLOW_BIT], fall[c]);
         cntNext = cnt_q[c] + 8'h01;
         cnt_d   = cnt_q[c];
         ff_d    = ff_q[c];
         match[c] = 1'b0;
         if (!ctrl_q[c].run) begin
            cnt_d = 8'h00;
         end else if (tick) begin
            if (cntNext == cmp_q[c]) begin
               cnt_d    = 8'h00;
               match[c] = 1'b1;
               if (ctrl_q[c].mode == MODE_DIVIDER) begin
                  ff_d = !ff_q[c];
               end
            end else begin
               cnt_d = cntNext;
            end
         end
         // Preload only while stopped, so a stop write leaves the pin level alone
         if (wrCtrl[c] && !ctrl_q[c].run) begin
            ff_d = wData_q[7];
         end
      end

      // Channel registers
      always_ff @(posedge clk) begin
         if (reset) begin
            cnt_q[c] <= 8'h00;
            ff_q[c]  <= 1'b0;
         end else begin
            cnt_q[c] <= cnt_d;
            ff_q[c]  <= ff_d;
         end
      end

      assign dividerOutputPin[c] = !ff_q[c];
      assign channelMatchIrq[c]  = match[c];

      property p_match_clears;
         match[c] |=> cnt_q[c] == 8'h00;
      endproperty
      a_match_clears: assert property (p_match_clears)
         else $error("count not cleared after match");

      property p_match_value;
         match[c] |-> (8'(cnt_q[c] + 8'h01) == cmp_q[c]) && ctrl_q[c].run;
      endproperty
      a_match_value: assert property (p_match_value)
         else $error("match without compare equality");

      property p_div_toggle;
         match[c] && ctrl_q[c].mode == MODE_DIVIDER |=> ff_q[c] != $past(ff_q[c]);
      endproperty
      a_div_toggle: assert property (p_div_toggle)
         else $error("divider flip-flop did not toggle");

      property p_ff_cause;
         !$stable(ff_q[c]) |-> $past(match[c]) || $past(wrCtrl[c] && !ctrl_q[c].run);
      endproperty
      a_ff_cause: assert property (p_ff_cause)
         else $error("flip-flop changed without cause");

      property p_pin_inverse;
         dividerOutputPin[c] == !ff_q[c];
      endproperty
      a_pin_inverse: assert property (p_pin_inverse)
         else $error("divider pin not inverse of flip-flop");

      property p_preload;
         wrCtrl[c] && !ctrl_q[c].run |=> ff_q[c] == $past(wData_q[7]);
      endproperty
      a_preload: assert property (p_preload)
         else $error("flip-flop preload failed");

      property p_stop_hold;
         wrCtrl[c] && ctrl_q[c].run && !wData_q[3] |=> ##1 $stable(ff_q[c]) [*2];
      endproperty
      a_stop_hold: assert property (p_stop_hold)
         else $error("pin level moved after stop");

      property p_event_count;
         ctrl_q[c].run && ctrl_q[c].mode == MODE_TIMER && ctrl_q[c].srcSel == SRC_PIN
            && fall[c] && !wrCtrl[c]
            |=> cnt_q[c] == 8'h00 || cnt_q[c] == 8'($past(cnt_q[c]) + 8'h01);
      endproperty
      a_event_count: assert property (p_event_count)
         else $error("falling edge not counted");

      c_div_match: cover property (match[c] && ctrl_q[c].mode == MODE_DIVIDER);
      c_event_match: cover property (match[c] && ctrl_q[c].srcSel == SRC_PIN);
      c_stop_preload: cover property (wrCtrl[c] && ctrl_q[c].run ##[1:20] wrCtrl[c]);
   end

endmodule : dtd_timer
`default_nettype wire

// ==== verif/dtd_far_model.sv ====
// Far-side model: count-pin source, low-frequency clock and divider-pin load.
// Assumes the bench calls pulse() and drives lowFreqEn and portLatch.
`timescale 1ns/1ps
`default_nettype none
module dtd_far_model (
   // Clock
   input  wire logic                     clk,
   // Towards the timer
   output logic [dtd_pkg::CH_N-1:0]      eventCountPin,
   output logic                          lowFreqClockPin,
   // Bench controls
   input  wire logic                     lowFreqEn,
   input  wire logic                     portLatch,
   // Divider output and what the load sees
   input  wire logic [dtd_pkg::CH_N-1:0] dividerOutputPin,
   output logic [dtd_pkg::CH_N-1:0]      loadLevel
);
   import dtd_pkg::*;
   logic [2:0] lfDiv = 3'h0;
   initial eventCountPin = 2'h3;
   initial lowFreqClockPin = 1'b0;
   // Slow clock toggles every 8 system clocks, parked low when disabled
   always @(posedge clk) begin
      lfDiv <= lfDiv + 3'h1;
      if (!lowFreqEn) lowFreqClockPin <= 1'b0;
      else if (lfDiv == 3'h7) lowFreqClockPin <= ~lowFreqClockPin;
   end
   // Pin reaches the load only through a port latch set to 1
   assign loadLevel = portLatch ? dividerOutputPin : 2'h0;
   // Falling edges with four-clock low and high phases
   task pulse(input int ch, input int n);
      repeat (n) begin
         @(posedge clk);
         eventCountPin[ch] <= 1'b0;
         repeat (4) @(posedge clk);
         eventCountPin[ch] <= 1'b1;
         repeat (3) @(posedge clk);
      end
   endtask : pulse
endmodule : dtd_far_model
`default_nettype wire

// ==== verif/dtd_tb.sv ====
// Self-checking bench for the dual 8-bit timer: AXI4-Lite tasks and directed sequences.
// Assumes dtd_pkg, dtd_timer and dtd_far_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
   import dtd_pkg::*;
   localparam int LIMIT = 20000;
   logic        clk = 1'b0, reset = 1'b1;
   logic        awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
   logic [7:0]  awAddr = 8'h00, arAddr = 8'h00;
   logic [31:0] wData = 32'h0, rData, rd;
   logic        awReady, wReady, bValid, arReady, rValid, lowFreqPin, p;
   logic        lowFreqEn = 1'b0;
   logic [3:0]  wStrb = 4'hF;
   logic [1:0]  bResp, rResp, rsp, pinCnt, divPin, matchIrq, loadLevel;
   int          n_mismatch = 0, total_checks = 0, cyc = 0, irqCnt0 = 0, t0, t1, t2, n0;
   always #2.5 clk = ~clk;
   dtd_timer dut_u (.clk(clk), .reset(reset), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
      .s_axi_awaddr(awAddr), .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_wdata(wData),
      .s_axi_wstrb(wStrb), .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_bresp(bResp),
      .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_araddr(arAddr),
      .s_axi_rvalid(rValid), .s_axi_rready(rReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
      .eventCountPin(pinCnt), .lowFreqClockPin(lowFreqPin), .dividerOutputPin(divPin),
      .channelMatchIrq(matchIrq));
   dtd_far_model far_u (.clk(clk), .eventCountPin(pinCnt), .lowFreqClockPin(lowFreqPin),
      .lowFreqEn(lowFreqEn), .portLatch(1'b1), .dividerOutputPin(divPin), .loadLevel(loadLevel));
   // Cycle count, match count and hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (matchIrq[0] === 1'b1) irqCnt0 <= irqCnt0 + 1;
      if (cyc == LIMIT) begin
         $display("BAD %0t timeout", $time);
         n_mismatch = n_mismatch + 1;
         summarize();
      end
   end
   task automatic summarize;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : summarize
   // Compare of bus and pin values
   task automatic chkVal(input logic [31:0] got, input logic [31:0] exp, input string msg);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask : chkVal
   // Compare of measured cycle counts
   task automatic chkCyc(input int got, input int exp, input string msg);
      total_checks++;
      if (got != exp) begin
         n_mismatch++;
         $display("BAD %0t %s got %0d exp %0d", $time, msg, got, exp);
      end
   endtask : chkCyc
   // Write: address and data offered together, each released when taken
   task automatic wrChk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      bit aw, w, b;
      aw = 0;
      w = 0;
      b = 0;
      rsp = 2'h3;
      @(posedge clk);
      awAddr <= a;
      wData <= d;
      awValid <= 1'b1;
      wValid <= 1'b1;
      bReady <= 1'b1;
      repeat (50) if (!b) begin
         @(posedge clk);
         if (!aw && awReady === 1'b1) begin aw = 1; awValid <= 1'b0; end
         if (!w && wReady === 1'b1) begin w = 1; wValid <= 1'b0; end
         if (bValid === 1'b1) begin b = 1; rsp = bResp; bReady <= 1'b0; end
      end
      chkVal(32'(rsp), 32'(er), "write response");
   endtask : wrChk
   // Read: address held until taken, rready held until data arrives
   task automatic rdChk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      bit ar, r;
      ar = 0;
      r = 0;
      rd = 32'hDEAD_BEEF;
      rsp = 2'h3;
      @(posedge clk);
      arAddr <= a;
      arValid <= 1'b1;
      rReady <= 1'b1;
      repeat (50) if (!r) begin
         @(posedge clk);
         if (!ar && arReady === 1'b1) begin ar = 1; arValid <= 1'b0; end
         if (rValid === 1'b1) begin r = 1; rd = rData; rsp = rResp; rReady <= 1'b0; end
      end
      chkVal(rd, ed, "read data");
      chkVal(32'(rsp), 32'(er), "read response");
   endtask : rdChk
   // Cycle stamp of the next match pulse
   task automatic waitIrq(input int ch, output int t);
      t = -1;
      repeat (3000) if (t < 0) begin
         @(posedge clk);
         if (matchIrq[ch] === 1'b1) t = cyc;
      end
   endtask : waitIrq
   // Cycle stamp of the divider pin reaching a level at the load
   task automatic waitPin(input int ch, input logic lvl, output int t);
      t = -1;
      repeat (3000) if (t < 0) begin
         @(posedge clk);
         if (loadLevel[ch] === lvl) t = cyc;
      end
   endtask : waitPin
   initial begin
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      chkVal(32'(divPin), 32'h3, "pins after reset");
      for (int i = 0; i < 6; i++) rdChk(8'(i * 4), 32'h0, RESP_OKAY);
      // Refused accesses
      rdChk(8'h18, 32'h0, RESP_SLVERR);
      rdChk(8'h02, 32'h0, RESP_SLVERR);
      wrChk(OFS_STAT, 32'hFF, RESP_SLVERR);
      // Timer on the divide-by-128 tap
      wrChk(OFS_CMP0, 32'h0A, RESP_OKAY);
      wrChk(OFS_CTRL0, 32'h10, RESP_OKAY);
      rdChk(OFS_CTRL0, 32'h10, RESP_OKAY);
      wrChk(OFS_CTRL0, 32'h18, RESP_OKAY);
      waitIrq(0, t0);
      waitIrq(0, t1);
      chkCyc(t1 - t0, 10 * (1 << TAP_FC7), "timer period");
      wrChk(OFS_CTRL0, 32'h10, RESP_OKAY);
      // Divider on channel 1
      wrChk(OFS_CMP1, 32'h02, RESP_OKAY);
      wrChk(OFS_CTRL1, 32'h31, RESP_OKAY);
      wrChk(OFS_CTRL1, 32'h39, RESP_OKAY);
      waitPin(1, 1'b0, t0);
      waitPin(1, 1'b1, t1);
      waitPin(1, 1'b0, t2);
      chkCyc(t1 - t0, 2 * (1 << TAP_FC3), "divider low phase");
      chkCyc(t2 - t1, 2 * (1 << TAP_FC3), "divider high phase");
      waitIrq(1, t0);
      waitIrq(1, t1);
      chkCyc(t1 - t0, 2 * (1 << TAP_FC3), "divider match period");
      wrChk(OFS_CTRL1, 32'h31, RESP_OKAY);
      p = divPin[1];
      repeat (40) @(posedge clk);
      chkVal(32'(divPin[1]), 32'(p), "pin held when stopped");
      rdChk(OFS_STAT, {14'h0000, !p, 17'h00000}, RESP_OKAY);
      wrChk(OFS_CTRL1, 32'hB1, RESP_OKAY);
      repeat (2) @(posedge clk);
      chkVal(32'(divPin[1]), 32'h0, "preload one");
      wrChk(OFS_CTRL1, 32'h31, RESP_OKAY);
      repeat (2) @(posedge clk);
      chkVal(32'(divPin[1]), 32'h1, "preload zero");
      // A write with byte lane 0 off leaves the register alone
      wStrb <= 4'h0;
      wrChk(OFS_CMP1, 32'h55, RESP_OKAY);
      wStrb <= 4'hF;
      rdChk(OFS_CMP1, 32'h2, RESP_OKAY);
      // Event counter on channel 0
      wrChk(OFS_CMP0, 32'h03, RESP_OKAY);
      wrChk(OFS_CTRL0, 32'h78, RESP_OKAY);
      n0 = irqCnt0;
      far_u.pulse(0, 7);
      repeat (10) @(posedge clk);
      chkCyc(irqCnt0 - n0, 2, "event matches");
      rdChk(OFS_STAT, 32'h1, RESP_OKAY);
      wrChk(OFS_CMP0, 32'h02, RESP_OKAY);
      n0 = irqCnt0;
      far_u.pulse(0, 1);
      repeat (10) @(posedge clk);
      chkCyc(irqCnt0 - n0, 1, "new compare at once");
      rdChk(OFS_STAT, 32'h0, RESP_OKAY);
      // Low-frequency tap
      wrChk(OFS_CTRL0, 32'h70, RESP_OKAY);
      wrChk(OFS_CFG, 32'h1, RESP_OKAY);
      rdChk(OFS_CFG, 32'h1, RESP_OKAY);
      lowFreqEn <= 1'b1;
      wrChk(OFS_CTRL0, 32'h08, RESP_OKAY);
      waitIrq(0, t0);
      waitIrq(0, t1);
      chkCyc(t1 - t0, 2 * 8 * 16, "slow tap period");
      // Unhandled mode code keeps the counter still
      wrChk(OFS_CTRL0, 32'h00, RESP_OKAY);
      wrChk(OFS_CTRL0, 32'h3A, RESP_OKAY);
      n0 = irqCnt0;
      repeat (300) @(posedge clk);
      chkCyc(irqCnt0 - n0, 0, "frozen mode");
      // Slow operation leaves only the low-frequency tap
      wrChk(OFS_CTRL0, 32'h32, RESP_OKAY);
      wrChk(OFS_CFG, 32'h2, RESP_OKAY);
      wrChk(OFS_CTRL0, 32'h38, RESP_OKAY);
      n0 = irqCnt0;
      repeat (300) @(posedge clk);
      chkCyc(irqCnt0 - n0, 0, "slow mode blocks fast tap");
      summarize();
   end
endmodule : tb
`default_nettype wire
